// ### pkg/fcsr_pkg.sv
// shared constants, types and helpers of the frequency counter readout block
package fcsr_pkg;
  // readback word layout
  localparam int RB_W        = 24;
  localparam int CNT_W       = 22;
  localparam int RB_DONE_POS = 23;
  localparam int RB_AUX_POS  = 22;
  // frame lengths in bits, as counted on the serial clock
  localparam int LEN_W = 5;
  localparam logic [LEN_W-1:0] CTRL_LEN = 5'h08;
  localparam logic [LEN_W-1:0] REF_LEN  = 5'h18;
  localparam logic [LEN_W-1:0] LEN_MAX  = 5'h1f;
  // control word fields (8-bit frame)
  localparam int CTRL_CONV_RD_POS   = 7;
  localparam int CTRL_FREQ_RD_POS   = 6;
  localparam int CTRL_CONV_SMPL_POS = 5;
  // reference word fields (24-bit frame)
  localparam int REF_FSMPL_POS = 23;
  localparam int REF_BAND_POS  = 16;
  localparam int REF_WIDE_POS  = 15;
  // window t = 2(19 + 2a) reference periods; the reference is clk_sys
  localparam int WIN_BASE_PERIODS = 19;
  localparam int WIN_STEP_PERIODS = 2;
  localparam int WIN_MULT         = 2;
  localparam int CLK_PER_REF      = 1;
  localparam int WIN_W            = 6;

  typedef enum logic [1:0] {G_IDLE, G_GATE, G_DONE} fcsr_gate_t;

  // window length in clk_sys cycles for the selected width
  function automatic logic [WIN_W-1:0] win_cycles(input logic wide);
    return WIN_W'(CLK_PER_REF * WIN_MULT * (WIN_BASE_PERIODS + WIN_STEP_PERIODS * int'(wide)));
  endfunction

  // rising edge of a sampled level
  function automatic logic rose(input logic prev, input logic cur);
    return cur & ~prev;
  endfunction

  // readback bit for a given shift position, msb first, zero past the end
  function automatic logic rb_pick(input logic [RB_W-1:0] w, input logic [LEN_W-1:0] i);
    logic [LEN_W-1:0] top;
    top = LEN_W'(RB_W - 1);
    return (i <= top) ? w[top - i] : 1'b0;
  endfunction
endpackage

// ### core/fcsr_gate_cnt.sv
// gated acquisition window and 22-stage edge counter
`timescale 1ns/1ps
module fcsr_gate_cnt (
  input  wire logic                      clk_sys,  // system clock
  input  wire logic                      resetn,   // async reset, active low
  input  wire logic                      start,    // pulse: open a new window
  input  wire logic                      clear,    // pulse: back to idle
  input  wire logic                      wide,     // window width select
  input  wire logic                      if_edge,  // pulse: edge of selected input
  output logic      [fcsr_pkg::CNT_W-1:0] count,   // frequency count
  output logic                           done      // count complete
);
  fcsr_pkg::fcsr_gate_t             state, next_state;
  logic [fcsr_pkg::WIN_W-1:0]       wcnt, next_wcnt;
  logic [fcsr_pkg::CNT_W-1:0]       next_count;
  logic                             next_done;

  // window sequencing; a restart during a window simply reopens it
  always_comb begin
    next_state = state;
    next_wcnt  = wcnt;
    next_count = count;
    next_done  = done;
    if (clear) begin
      next_state = fcsr_pkg::G_IDLE;
      next_done  = 1'b0;
    end else if (start) begin
      next_state = fcsr_pkg::G_GATE;
      next_wcnt  = fcsr_pkg::win_cycles(wide) - 6'h1;
      next_count = '0;
      next_done  = 1'b0;
    end else begin
      case (state)
        fcsr_pkg::G_GATE: begin
          if (if_edge) begin
            next_count = count + 22'h1;
          end
          if (wcnt == '0) begin
            next_state = fcsr_pkg::G_DONE;
            next_done  = 1'b1;
          end else begin
            next_wcnt = wcnt - 6'h1;
          end
        end
        fcsr_pkg::G_IDLE, fcsr_pkg::G_DONE: begin
          next_state = state;
        end
        default: begin
          next_state = fcsr_pkg::G_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state <= fcsr_pkg::G_IDLE;
      wcnt  <= '0;
      count <= '0;
      done  <= 1'b0;
    end else begin
      state <= next_state;
      wcnt  <= next_wcnt;
      count <= next_count;
      done  <= next_done;
    end
  end

  // helper for checks: measured window length against the expected one
  logic [fcsr_pkg::WIN_W-1:0] hlp_len, hlp_win;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      hlp_len <= '0;
      hlp_win <= '0;
    end else if (start) begin
      hlp_len <= '0;
      hlp_win <= fcsr_pkg::win_cycles(wide);
    end else if (state == fcsr_pkg::G_GATE) begin
      hlp_len <= hlp_len + 6'h1;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  sequence s_open;
    start && !clear;
  endsequence
  sequence s_close;
    state == fcsr_pkg::G_GATE && wcnt == '0 && !start && !clear;
  endsequence

  chk_window_len: assert property ($rose(done) |-> hlp_len == hlp_win)
    else $error("acquisition window length wrong");
  chk_done_at_close: assert property (s_close |=> done && state == fcsr_pkg::G_DONE)
    else $error("count complete not raised at window end");
  chk_count_cleared: assert property (s_open |=> count == '0 && !done)
    else $error("count not cleared at window start");
  chk_count_edge: assert property (
      state == fcsr_pkg::G_GATE && !start && !clear && if_edge
      |=> count == $past(count) + 22'h1)
    else $error("edge not counted during window");
endmodule // fcsr_gate_cnt

// ### core/fcsr_top.sv
// serial port, readout register and band selection of the frequency counter
`timescale 1ns/1ps
module fcsr_top (
  input  wire logic clk_sys,               // system and reference clock, 50 MHz
  input  wire logic resetn,                // async reset, active low
  input  wire logic serial_clk,            // serial clock from the host
  input  wire logic serial_latch_enable_n, // frame enable, low during a frame
  input  wire logic serial_data_in,        // serial data, sampled on rising edge
  output logic      serial_data_out,       // readback data, launched on rising edge
  input  wire logic aux_in,                // auxiliary digital input pin
  input  wire logic if_hf_in,              // intermediate frequency, low band
  input  wire logic if_vhf_in,             // intermediate frequency, high band
  output logic      band_select,           // 0 low band, 1 high band
  output logic      freq_sample_start,     // acquisition enabled
  output logic      conv_sample_start,     // converter sampling bit
  output logic      conv_read_req,         // converter readout request
  output logic      freq_read_req,         // frequency readout request
  output logic      count_done_flag        // count complete
);
  // ---------------- link side, on the serial clock ----------------
  logic                               armed, next_armed;
  logic [fcsr_pkg::LEN_W-1:0]         bit_cnt, next_bit_cnt;
  logic [fcsr_pkg::RB_W-1:0]          shift_in, next_shift_in;
  logic                               next_sdo;
  logic [fcsr_pkg::RB_W-1:0]          rb_word;   // system domain, static in a frame
  logic [fcsr_pkg::LEN_W-1:0]         rd_idx;

  // the first edge of a frame restarts the count; the count saturates at 31
  always_comb begin
    rd_idx        = armed ? '0 : bit_cnt;
    next_armed    = 1'b0;
    next_bit_cnt  = armed ? 5'h01 : (bit_cnt == fcsr_pkg::LEN_MAX ? bit_cnt : bit_cnt + 5'h01);
    next_shift_in = {shift_in[fcsr_pkg::RB_W-2:0], serial_data_in};
    next_sdo      = fcsr_pkg::rb_pick(rb_word, rd_idx);
    // a stray clock outside a frame must not disturb what the system side decodes
    if (serial_latch_enable_n) begin
      next_bit_cnt  = bit_cnt;
      next_shift_in = shift_in;
      next_sdo      = serial_data_out;
    end
  end

  // latch enable high presets the arm flag only; the frame length and
  // shifted bits must survive it so the system side can decode them
  always_ff @(posedge serial_clk or negedge resetn or posedge serial_latch_enable_n) begin
    if (!resetn) begin
      armed <= 1'b1;
    end else if (serial_latch_enable_n) begin
      armed <= 1'b1;
    end else begin
      armed <= next_armed;
    end
  end

  // shift state keeps a plain async reset so it maps onto ordinary flops
  always_ff @(posedge serial_clk or negedge resetn) begin
    if (!resetn) begin
      bit_cnt         <= '0;
      shift_in        <= '0;
      serial_data_out <= 1'b0;
    end else begin
      bit_cnt         <= next_bit_cnt;
      shift_in        <= next_shift_in;
      serial_data_out <= next_sdo;
    end
  end

  // ---------------- system side ----------------
  logic enb_m, enb_s, enb_d;
  logic aux_m, aux_s;
  logic hf_m, hf_s, hf_d;
  logic vhf_m, vhf_s, vhf_d;

  // two-stage synchronisers; logic reads the second stage, edge detectors also a third delayed stage
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      enb_m <= 1'b1;
      enb_s <= 1'b1;
      enb_d <= 1'b1;
      aux_m <= 1'b0;
      aux_s <= 1'b0;
      hf_m  <= 1'b0;
      hf_s  <= 1'b0;
      hf_d  <= 1'b0;
      vhf_m <= 1'b0;
      vhf_s <= 1'b0;
      vhf_d <= 1'b0;
    end else begin
      enb_m <= serial_latch_enable_n;
      enb_s <= enb_m;
      enb_d <= enb_s;
      aux_m <= aux_in;
      aux_s <= aux_m;
      hf_m  <= if_hf_in;
      hf_s  <= hf_m;
      hf_d  <= hf_s;
      vhf_m <= if_vhf_in;
      vhf_s <= vhf_m;
      vhf_d <= vhf_s;
    end
  end

  logic frame_open, frame_close, if_edge;
  logic [fcsr_pkg::CNT_W-1:0] count;
  logic wide, start_p, clear_p;
  logic next_wide, next_start_p, next_clear_p, next_band, next_fss;
  logic next_conv_smpl, next_conv_rd, next_freq_rd;
  logic [fcsr_pkg::RB_W-1:0] next_rb_word;
  logic serve_freq;

  // frame edges seen through the synchroniser; the band bit picks the input
  always_comb begin
    frame_open  = enb_d & ~enb_s;
    frame_close = fcsr_pkg::rose(enb_d, enb_s);
    if_edge     = band_select ? fcsr_pkg::rose(vhf_d, vhf_s)
                              : fcsr_pkg::rose(hf_d, hf_s);
    serve_freq  = freq_read_req & ~conv_read_req;
  end

  // register writes at frame close; shift_in and bit_cnt are stable then
  // because the link side holds them while the latch enable is high
  always_comb begin
    next_rb_word   = rb_word;
    next_wide      = wide;
    next_band      = band_select;
    next_fss       = freq_sample_start;
    next_conv_smpl = conv_sample_start;
    next_conv_rd   = conv_read_req;
    next_freq_rd   = freq_read_req;
    next_start_p   = 1'b0;
    next_clear_p   = 1'b0;
    if (frame_open) begin
      // snapshot taken as the frame opens, aux level sampled with it
      next_rb_word = serve_freq ? {count_done_flag, aux_s, count} : '0;
    end
    if (frame_close) begin
      if (freq_read_req || conv_read_req) begin
        // the readback frame consumes the request, writes are dropped
        next_freq_rd = 1'b0;
        next_conv_rd = 1'b0;
      end else if (bit_cnt == fcsr_pkg::CTRL_LEN) begin
        next_conv_rd   = shift_in[fcsr_pkg::CTRL_CONV_RD_POS];
        next_freq_rd   = shift_in[fcsr_pkg::CTRL_FREQ_RD_POS];
        next_conv_smpl = shift_in[fcsr_pkg::CTRL_CONV_SMPL_POS];
      end else if (bit_cnt == fcsr_pkg::REF_LEN) begin
        next_band    = shift_in[fcsr_pkg::REF_BAND_POS];
        next_wide    = shift_in[fcsr_pkg::REF_WIDE_POS];
        next_fss     = shift_in[fcsr_pkg::REF_FSMPL_POS];
        // only a 0 to 1 step starts; rewriting 1 leaves the count alone
        next_start_p = shift_in[fcsr_pkg::REF_FSMPL_POS] & ~freq_sample_start;
        next_clear_p = ~shift_in[fcsr_pkg::REF_FSMPL_POS];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rb_word           <= '0;
      wide              <= 1'b0;
      band_select       <= 1'b0;
      freq_sample_start <= 1'b0;
      conv_sample_start <= 1'b0;
      conv_read_req     <= 1'b0;
      freq_read_req     <= 1'b0;
      start_p           <= 1'b0;
      clear_p           <= 1'b0;
    end else begin
      rb_word           <= next_rb_word;
      wide              <= next_wide;
      band_select       <= next_band;
      freq_sample_start <= next_fss;
      conv_sample_start <= next_conv_smpl;
      conv_read_req     <= next_conv_rd;
      freq_read_req     <= next_freq_rd;
      start_p           <= next_start_p;
      clear_p           <= next_clear_p;
    end
  end

  // window gate and counter; done is a flop inside, fed straight out
  fcsr_gate_cnt u_gate (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .start   (start_p),
    .clear   (clear_p),
    .wide    (wide),
    .if_edge (if_edge),
    .count   (count),
    .done    (count_done_flag)
  );

  // ---------------- checks ----------------
  sequence s_freq_open;
    frame_open && serve_freq;
  endsequence

  chk_readback_layout: assert property (@(posedge clk_sys) disable iff (!resetn)
      s_freq_open |=> rb_word[fcsr_pkg::RB_DONE_POS] == $past(count_done_flag)
                      && rb_word[fcsr_pkg::CNT_W-1:0] == $past(count))
    else $error("readback word layout wrong");
  chk_aux_capture: assert property (@(posedge clk_sys) disable iff (!resetn)
      s_freq_open |=> rb_word[fcsr_pkg::RB_AUX_POS] == $past(aux_s))
    else $error("auxiliary level not captured");
  chk_read_autoclear: assert property (@(posedge clk_sys) disable iff (!resetn)
      frame_close && freq_read_req |=> !freq_read_req)
    else $error("read request not cleared after readback");
  chk_write_ignored: assert property (@(posedge clk_sys) disable iff (!resetn)
      frame_close && (freq_read_req || conv_read_req)
      |=> $stable(band_select) && $stable(wide) && $stable(freq_sample_start))
    else $error("write taken while read request set");
  chk_conv_wins: assert property (@(posedge clk_sys) disable iff (!resetn)
      frame_open && conv_read_req |=> rb_word == '0)
    else $error("frequency readback served over converter read");
  chk_start_write: assert property (@(posedge clk_sys) disable iff (!resetn)
      frame_close && !freq_read_req && !conv_read_req && bit_cnt == fcsr_pkg::REF_LEN
      && shift_in[fcsr_pkg::REF_FSMPL_POS] && !freq_sample_start
      |=> start_p ##1 !count_done_flag)
    else $error("sample-start write did not open a window");
  chk_msb_first: assert property (@(posedge serial_clk)
      disable iff (!resetn || serial_latch_enable_n)
      armed |=> serial_data_out == rb_word[fcsr_pkg::RB_DONE_POS])
    else $error("readback not shifted msb first");
endmodule // fcsr_top

// ### dv/fcsr_host_model.sv
// host side model: drives the serial port frames and samples the readback
`timescale 1ns/1ps
module fcsr_host_model (
  output logic     serial_clk,            // serial clock, still outside frames
  output logic     serial_latch_enable_n, // frame enable, low in a frame
  output logic     serial_data_in,        // write data, msb first
  input wire logic serial_data_out        // readback data from the device
);
  localparam time HALF = 24;

  // idle: enable high, clock parked low
  initial begin
    serial_clk            = 1'b0;
    serial_latch_enable_n = 1'b1;
    serial_data_in        = 1'b1;
  end

  // one frame of nbits; readback taken on each falling clock
  task automatic frame(input int nbits, input logic [23:0] wdata, output logic [23:0] rdata);
    rdata                 = 24'h000000;
    serial_latch_enable_n = 1'b0;
    #100;  // setup after enable fall, above the 80 ns minimum
    for (int i = nbits - 1; i >= 0; i--) begin
      serial_data_in = wdata[i];
      #HALF serial_clk = 1'b1;
      #HALF serial_clk = 1'b0;
      rdata = {rdata[22:0], serial_data_out};
    end
    #HALF serial_latch_enable_n = 1'b1;
    serial_data_in = ~serial_data_in;  // released line shows no stale value
    #100;  // enable high gap, lets registers settle
  endtask

  // control word; read requests only in a write of their own
  task automatic ctrl(input logic [7:0] v);
    logic [23:0] r;
    frame(8, {16'h0000, v}, r);
  endtask

  // reference word with sample start, band and window width
  task automatic ref_word(input logic fs, input logic b, input logic w);
    logic [23:0] r;
    frame(24, {fs, 6'h00, b, w, 15'h0000}, r);
  endtask
endmodule // fcsr_host_model

// ### dv/freq_counter_serial_readout_tb.sv
// self-checking testbench of the frequency counter readout block
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin failures++; \
  $display("Error %s expected %0h seen %0h", nm, ex, got); end end
module freq_counter_serial_readout_tb;
  logic       clk_sys = 1'b0, resetn, aux_in, if_hf_in, if_vhf_in;
  wire logic  serial_clk, serial_latch_enable_n, serial_data_in, serial_data_out;
  wire logic  band_select, freq_sample_start, conv_sample_start;
  wire logic  conv_read_req, freq_read_req, count_done_flag;
  int         failures = 0, checked = 0, pulses = 0, ph = 0, lat = 0, lat_cnt = 0;
  logic       band = 1'b0, sel_lvl = 1'b0, other_lvl = 1'b0, fss_q = 1'b0, done_q = 1'b0;
  logic [23:0] rd;
  logic [23:0] exp_q[$];

  always #10 clk_sys = ~clk_sys;

  fcsr_top uut (.clk_sys(clk_sys), .resetn(resetn), .serial_clk(serial_clk),
    .serial_latch_enable_n(serial_latch_enable_n), .serial_data_in(serial_data_in),
    .serial_data_out(serial_data_out), .aux_in(aux_in), .if_hf_in(if_hf_in),
    .if_vhf_in(if_vhf_in), .band_select(band_select), .freq_sample_start(freq_sample_start),
    .conv_sample_start(conv_sample_start), .conv_read_req(conv_read_req),
    .freq_read_req(freq_read_req), .count_done_flag(count_done_flag));
  fcsr_host_model host (.serial_clk(serial_clk), .serial_latch_enable_n(serial_latch_enable_n),
    .serial_data_in(serial_data_in), .serial_data_out(serial_data_out));

  // if stimulus: counted pulses on the selected input, noise on the other
  always @(posedge clk_sys) begin
    #1;
    ph = (ph == 5) ? 0 : ph + 1;
    if (ph == 0) other_lvl = 1'($urandom_range(1));
    if (ph == 0 && pulses > 0) sel_lvl = 1'b1;
    if (ph == 3 && sel_lvl) begin
      sel_lvl = 1'b0;
      pulses--;
    end
    if_hf_in  = band ? other_lvl : sel_lvl;
    if_vhf_in = band ? sel_lvl : other_lvl;
  end

  // cycles from sample start rising to the done flag rising; looked at
  // just after the edge so both flags are settled, never mid-update
  always @(posedge clk_sys) begin
    #1;
    lat_cnt = (freq_sample_start && !fss_q) ? 0 : lat_cnt + 1;
    if (count_done_flag && !done_q) lat = lat_cnt;
    fss_q  = freq_sample_start;
    done_q = count_done_flag;
  end

  task automatic conclude();
    $display("failures %0d checked %0d", failures, checked);
    if (failures == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // watchdog, far beyond the expected run of about 33 us
  initial begin
    #1_000_000;
    failures++;
    $display("Error watchdog expected finish seen timeout");
    conclude();
  end

  initial begin
    resetn = 1'b0;
    void'($urandom(74));
    aux_in = 1'($urandom);
    repeat (20) @(posedge clk_sys);
    #1 resetn = 1'b1;
    `CHK("reset_outputs", 6'h00, {band_select, freq_sample_start, conv_sample_start, conv_read_req, freq_read_req, count_done_flag})
    repeat (4) @(posedge clk_sys);
    #1;
    // every band and window width: acquire, then read back
    for (int m = 0; m < 4; m++) begin
      logic aux_v;
      logic [23:0] exp_w;
      int   k, win, t;
      band = m[0];
      host.ctrl(8'h00);
      host.ref_word(1'b0, band, m[1]);
      `CHK("band_select", band, band_select)
      `CHK("count_done_flag", 1'b0, count_done_flag)
      k = 1 + $urandom_range(3);
      host.ref_word(1'b1, band, m[1]);
      @(posedge clk_sys);
      #1 pulses = k;
      for (t = 0; t < 100 && count_done_flag !== 1'b1; t++) @(posedge clk_sys);
      @(posedge clk_sys);
      #1 win = m[1] ? 42 : 38;
      `CHK("count_done_flag", 1'b1, count_done_flag)
      `CHK("window", win + 1, lat)
      aux_v  = 1'($urandom);
      aux_in = aux_v;
      exp_q.push_back({1'b1, aux_v, 22'(k)});
      host.ctrl(8'h40);
      `CHK("freq_read_req", 1'b1, freq_read_req)
      // write data in the readback frame must be dropped
      host.frame(24, {7'h00, ~band, 16'h0000}, rd);
      exp_w = exp_q.pop_front();
      `CHK("readback", exp_w, rd)
      `CHK("freq_read_req", 1'b0, freq_read_req)
      `CHK("band_select", band, band_select)
      `CHK("freq_sample_start", 1'b1, freq_sample_start)
    end
    // read after sample start is cleared: flag low
    band = 1'b0;
    host.ref_word(1'b0, 1'b0, 1'b0);
    host.ctrl(8'h40);
    host.frame(24, 24'h000000, rd);
    `CHK("done_bit", 1'b0, rd[23])
    // both requests: converter read wins, frequency word not sent
    host.ctrl(8'hc0);
    `CHK("conv_read_req", 1'b1, conv_read_req)
    host.frame(24, 24'h000000, rd);
    `CHK("conv_wins", 24'h000000, rd)
    `CHK("read_reqs", 2'b00, {conv_read_req, freq_read_req})
    // converter sample bit stored; a 16-bit frame is refused, and the
    // low bit left in the shifter would land on band select if decoded
    host.ctrl(8'h21);
    host.frame(16, 24'h00ffff, rd);
    `CHK("stored_bits", 3'b100, {conv_sample_start, band_select, freq_sample_start})
    host.ctrl(8'h00);
    conclude();
  end
endmodule // freq_counter_serial_readout_tb
